// *** logic/scratchpad_eeprom_access.sv ***
`timescale 1ns/10ps
module scratchpad_eeprom_access #(
	// Identity values are arbitrary
	parameter logic [7:0] FAMILY_CODE = 8'hA5,
	parameter logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0001
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Bit-slot layer events
	input wire logic bus_reset_i,
	input wire logic reset_std_speed_i,
	input wire logic bit_rx_valid_i,
	input wire logic bit_rx_i,
	input wire logic bit_tx_req_i,
	input wire logic power_lost_i,
	// Bit to send and speed
	output logic bit_tx_o,
	output logic overdrive_speed_select_o,
	// Register view
	output logic [7:0] target_address_low_o,
	output logic [7:0] target_address_high_o,
	output logic [7:0] ending_offset_status_o
);
	localparam logic [55:0] ID_BODY = {SERIAL_NUMBER, FAMILY_CODE};
	localparam logic [7:0] ID_CRC =
		scratchpad_eeprom_pkg::crc8_run(8'h00, {8'h00, ID_BODY}, 56);
	localparam logic [63:0] ROM_ID = {ID_CRC, ID_BODY};
	localparam logic [7:0] ID_CHECK =
		scratchpad_eeprom_pkg::crc8_run(ID_CRC, {56'h0, ID_CRC}, 8);
	localparam logic [15:0] CRC16_SEED = scratchpad_eeprom_pkg::crc16_byte(
		16'h0000, scratchpad_eeprom_pkg::MEM_WRITE_SP);
	if (ID_CHECK != 8'h00) begin : g_bad_id
		$error("identity CRC does not close to zero");
	end
	scratchpad_eeprom_pkg::state_t state;
	scratchpad_eeprom_pkg::es_t es;
	logic [2:0] bit_cnt;
	logic [6:0] rx_byte;
	logic [5:0] rom_idx;
	logic [1:0] phase;
	logic [1:0] byte_idx;
	logic [7:0] cmd;
	logic [9:0] ptr;
	logic [7:0] ta_low;
	logic [7:0] ta_high;
	logic [15:0] crc;
	logic od;
	logic [7:0] tx_byte;
	logic next_tx_bit;
	logic answer_bit;
	logic [7:0] mem [512];
	logic [7:0] sp [32];

	// Byte assembly and decode
	wire [7:0] rx_full = {bit_rx_i, rx_byte};
	wire rx_done = bit_rx_valid_i && (bit_cnt == scratchpad_eeprom_pkg::BIT_LAST);
	wire tx_done = bit_tx_req_i && (bit_cnt == scratchpad_eeprom_pkg::BIT_LAST);
	wire rom_bit = ROM_ID[rom_idx];
	wire rom_last = (rom_idx == scratchpad_eeprom_pkg::ROM_LAST);
	wire [7:0] hdr_byte = (byte_idx == 2'h0) ? ta_low :
		(byte_idx == 2'h1) ? ta_high : es;
	wire [7:0] sp_rd = ptr[5] ? scratchpad_eeprom_pkg::FILL_BYTE : sp[ptr[4:0]];
	wire [7:0] mem_rd = ptr[9] ? scratchpad_eeprom_pkg::FILL_BYTE :
		mem[ptr[8:0]];
	wire [15:0] crc_inv = ~crc;
	wire wr_cmd_go = (state == scratchpad_eeprom_pkg::MEM_CMD) && rx_done &&
		(rx_full == scratchpad_eeprom_pkg::MEM_WRITE_SP);
	wire store = (state == scratchpad_eeprom_pkg::WR_DATA) && rx_done;
	wire auth_ok = (state == scratchpad_eeprom_pkg::CP_AUTH) && rx_done &&
		(byte_idx == scratchpad_eeprom_pkg::HDR_LAST) && (rx_full == hdr_byte);
	wire partial_end = bus_reset_i && (bit_cnt != 3'h0) &&
		(state == scratchpad_eeprom_pkg::WR_DATA);
	wire crc_feed = bit_rx_valid_i &&
		((state == scratchpad_eeprom_pkg::WR_DATA) ||
		((state == scratchpad_eeprom_pkg::ADDR_IN) &&
		(cmd == scratchpad_eeprom_pkg::MEM_WRITE_SP)));
	wire [3:0] page = {ta_high[0], ta_low[7:5]};

	// Outputs straight from flops
	assign bit_tx_o = answer_bit;
	assign overdrive_speed_select_o = od;
	assign target_address_low_o = ta_low;
	assign target_address_high_o = ta_high;
	assign ending_offset_status_o = es;

	// Byte the current state presents to read slots
	always_comb begin
		unique case (state)
			scratchpad_eeprom_pkg::WR_CRC:
				tx_byte = byte_idx[0] ? crc_inv[15:8] : crc_inv[7:0];
			scratchpad_eeprom_pkg::RD_SP:
				tx_byte = (byte_idx == scratchpad_eeprom_pkg::HDR_DATA) ?
					sp_rd : hdr_byte;
			scratchpad_eeprom_pkg::CP_DONE:
				tx_byte = scratchpad_eeprom_pkg::ALT_BYTE;
			scratchpad_eeprom_pkg::RD_MEM: tx_byte = mem_rd;
			default: tx_byte = scratchpad_eeprom_pkg::FILL_BYTE;
		endcase
	end

	always_comb begin
		if (state == scratchpad_eeprom_pkg::ROM_READ) begin
			next_tx_bit = rom_bit;
		end else if (state == scratchpad_eeprom_pkg::ROM_SEARCH) begin
			next_tx_bit = (phase == 2'h0) ? rom_bit : ~rom_bit;
		end else begin
			next_tx_bit = tx_byte[bit_cnt];
		end
	end

	// Bit counter and shifter, realigned by every bus reset
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || bus_reset_i) begin
			bit_cnt <= 3'h0;
			rx_byte <= 7'h00;
		end else begin
			if (bit_rx_valid_i || bit_tx_req_i) begin
				bit_cnt <= bit_cnt + 3'h1;
			end
			if (bit_rx_valid_i) begin
				rx_byte <= rx_full[7:1];
			end
		end
	end

	// Read data registered one cycle ahead of the slot
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			answer_bit <= 1'b1;
		end else begin
			answer_bit <= next_tx_bit;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			es <= scratchpad_eeprom_pkg::ES_RESET;
		end else begin
			if (wr_cmd_go) begin
				es.copy_accepted_flag <= 1'b0;
			end
			if (store) begin
				es.ending_offset <= ptr[4:0];
				es.partial_flag <= 1'b0;
			end
			// accepted with partial clear means copied
			if (auth_ok) begin
				es.copy_accepted_flag <= 1'b1;
			end
			if (partial_end || power_lost_i) begin
				es.partial_flag <= 1'b1;
			end
			es.zero <= 1'b0;
		end
	end

	// CRC16 over command, address and data bits
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			crc <= 16'h0000;
		end else if (wr_cmd_go) begin
			crc <= CRC16_SEED;
		end else if (crc_feed) begin
			crc <= scratchpad_eeprom_pkg::crc16_bit(crc, bit_rx_i);
		end
	end

	// Arrays carry no reset; memory keeps content across resets
	always_ff @(posedge clk_i) begin
		if (store) begin
			sp[ptr[4:0]] <= rx_full;
		end
		if (auth_ok) begin
			for (int i = 0; i < 32; i++) begin
				if ((5'(i) >= ta_low[4:0]) && (5'(i) <= es.ending_offset)) begin
					mem[{page, 5'(i)}] <= sp[i];
				end
			end
		end
	end

	// Protocol sequencer
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state <= scratchpad_eeprom_pkg::ROM_CMD;
			rom_idx <= 6'h00;
			phase <= 2'h0;
			byte_idx <= 2'h0;
			cmd <= 8'h00;
			ptr <= 10'h000;
			ta_low <= 8'h00;
			ta_high <= 8'h00;
			od <= 1'b0;
		end else if (bus_reset_i) begin
			state <= scratchpad_eeprom_pkg::ROM_CMD;
			rom_idx <= 6'h00;
			phase <= 2'h0;
			byte_idx <= 2'h0;
			if (reset_std_speed_i) begin
				od <= 1'b0;
			end
		end else begin
			unique case (state)
				scratchpad_eeprom_pkg::ROM_CMD: if (rx_done) begin
					cmd <= rx_full;
					case (rx_full)
						scratchpad_eeprom_pkg::ROM_READ_CMD:
							state <= scratchpad_eeprom_pkg::ROM_READ;
						scratchpad_eeprom_pkg::ROM_MATCH_CMD,
						scratchpad_eeprom_pkg::ROM_OD_MATCH_CMD:
							state <= scratchpad_eeprom_pkg::ROM_MATCH;
						scratchpad_eeprom_pkg::ROM_SEARCH_CMD:
							state <= scratchpad_eeprom_pkg::ROM_SEARCH;
						scratchpad_eeprom_pkg::ROM_SKIP_CMD:
							state <= scratchpad_eeprom_pkg::MEM_CMD;
						scratchpad_eeprom_pkg::ROM_OD_SKIP_CMD: begin
							state <= scratchpad_eeprom_pkg::MEM_CMD;
							od <= 1'b1;
						end
						default: state <= scratchpad_eeprom_pkg::IDLE;
					endcase
				end
				scratchpad_eeprom_pkg::ROM_READ: if (bit_tx_req_i) begin
					rom_idx <= rom_idx + 6'h01;
					if (rom_last) begin
						state <= scratchpad_eeprom_pkg::MEM_CMD;
					end
				end
				scratchpad_eeprom_pkg::ROM_MATCH: if (bit_rx_valid_i) begin
					rom_idx <= rom_idx + 6'h01;
					if (bit_rx_i != rom_bit) begin
						state <= scratchpad_eeprom_pkg::IDLE;
					end else if (rom_last) begin
						state <= scratchpad_eeprom_pkg::MEM_CMD;
						if (cmd == scratchpad_eeprom_pkg::ROM_OD_MATCH_CMD) begin
							od <= 1'b1;
						end
					end
				end
				// Bit, complement, then master choice
				scratchpad_eeprom_pkg::ROM_SEARCH: begin
					if (phase != scratchpad_eeprom_pkg::SEARCH_RX) begin
						if (bit_tx_req_i) begin
							phase <= phase + 2'h1;
						end
					end else if (bit_rx_valid_i) begin
						phase <= 2'h0;
						rom_idx <= rom_idx + 6'h01;
						if (bit_rx_i != rom_bit) begin
							state <= scratchpad_eeprom_pkg::IDLE;
						end else if (rom_last) begin
							state <= scratchpad_eeprom_pkg::MEM_CMD;
						end
					end
				end
				scratchpad_eeprom_pkg::MEM_CMD: if (rx_done) begin
					cmd <= rx_full;
					byte_idx <= 2'h0;
					ptr <= {5'h00, ta_low[4:0]};
					case (rx_full)
						scratchpad_eeprom_pkg::MEM_WRITE_SP,
						scratchpad_eeprom_pkg::MEM_READ_MEM:
							state <= scratchpad_eeprom_pkg::ADDR_IN;
						scratchpad_eeprom_pkg::MEM_READ_SP:
							state <= scratchpad_eeprom_pkg::RD_SP;
						scratchpad_eeprom_pkg::MEM_COPY_SP:
							state <= scratchpad_eeprom_pkg::CP_AUTH;
						default: state <= scratchpad_eeprom_pkg::IDLE;
					endcase
				end
				scratchpad_eeprom_pkg::ADDR_IN: if (rx_done) begin
					if (byte_idx == 2'h0) begin
						ta_low <= rx_full;
						byte_idx <= 2'h1;
					end else begin
						ta_high <= rx_full & scratchpad_eeprom_pkg::ADDR_HIGH_MASK;
						if (cmd == scratchpad_eeprom_pkg::MEM_WRITE_SP) begin
							ptr <= {5'h00, ta_low[4:0]};
							state <= scratchpad_eeprom_pkg::WR_DATA;
						end else begin
							ptr <= {1'b0, rx_full[0], ta_low};
							state <= scratchpad_eeprom_pkg::RD_MEM;
						end
					end
				end
				scratchpad_eeprom_pkg::WR_DATA: if (rx_done) begin
					if (ptr[4:0] == scratchpad_eeprom_pkg::SP_LAST) begin
						state <= scratchpad_eeprom_pkg::WR_CRC;
						byte_idx <= 2'h0;
					end else begin
						ptr <= ptr + 10'h001;
					end
				end
				scratchpad_eeprom_pkg::WR_CRC: if (tx_done) begin
					if (byte_idx[0]) begin
						state <= scratchpad_eeprom_pkg::IDLE;
					end
					byte_idx <= 2'h1;
				end
				scratchpad_eeprom_pkg::RD_SP: if (tx_done) begin
					if (byte_idx != scratchpad_eeprom_pkg::HDR_DATA) begin
						byte_idx <= byte_idx + 2'h1;
					end else if (!ptr[5]) begin
						ptr <= ptr + 10'h001;
					end
				end
				scratchpad_eeprom_pkg::CP_AUTH: if (rx_done) begin
					if (rx_full != hdr_byte) begin
						state <= scratchpad_eeprom_pkg::IDLE;
					end else if (byte_idx == scratchpad_eeprom_pkg::HDR_LAST) begin
						state <= scratchpad_eeprom_pkg::CP_DONE;
					end else begin
						byte_idx <= byte_idx + 2'h1;
					end
				end
				scratchpad_eeprom_pkg::RD_MEM: if (tx_done && !ptr[9]) begin
					ptr <= ptr + 10'h001;
				end
				scratchpad_eeprom_pkg::CP_DONE,
				scratchpad_eeprom_pkg::IDLE: state <= state;
			endcase
		end
	end

	// Checks on the sequencer and status byte
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	rom_first_a: assert property (bus_reset_i |=> state == scratchpad_eeprom_pkg::ROM_CMD) else $error("no return to ROM stage");
	od_enter_a: assert property ((state == scratchpad_eeprom_pkg::ROM_CMD) && rx_done && (rx_full == scratchpad_eeprom_pkg::ROM_OD_SKIP_CMD) && !bus_reset_i |=> od && (state == scratchpad_eeprom_pkg::MEM_CMD)) else $error("overdrive not entered");
	bad_cmd_a: assert property ((state == scratchpad_eeprom_pkg::MEM_CMD) && rx_done && !bus_reset_i && (rx_full != scratchpad_eeprom_pkg::MEM_WRITE_SP) && (rx_full != scratchpad_eeprom_pkg::MEM_READ_SP) && (rx_full != scratchpad_eeprom_pkg::MEM_COPY_SP) && (rx_full != scratchpad_eeprom_pkg::MEM_READ_MEM) |=> state == scratchpad_eeprom_pkg::IDLE) else $error("unknown command accepted");
	addr_lsb_a: assert property ((state == scratchpad_eeprom_pkg::ADDR_IN) && rx_done && (byte_idx == 2'h0) && !bus_reset_i |=> ta_low == $past(rx_full)) else $error("address byte misassembled");
	es_ro_a: assert property ($changed(es.ending_offset) |-> $past(store)) else $error("offset changed without store");
	bit6_zero_a: assert property (ending_offset_status_o[6] == 1'b0) else $error("status bit six set");
	full_stop_a: assert property (store && (ptr[4:0] == scratchpad_eeprom_pkg::SP_LAST) && !bus_reset_i |=> (state == scratchpad_eeprom_pkg::WR_CRC) ##0 (es.ending_offset == scratchpad_eeprom_pkg::SP_LAST)) else $error("scratchpad did not stop");
	aa_clear_a: assert property (wr_cmd_go |=> !es.copy_accepted_flag) else $error("accepted flag kept");
	pf_set_a: assert property (partial_end |=> es.partial_flag && (state == scratchpad_eeprom_pkg::ROM_CMD)) else $error("partial byte not flagged");
	pf_clr_a: assert property (store && !power_lost_i |=> !es.partial_flag) else $error("valid write left partial set");
	mask_hi_a: assert property (ta_high[7:1] == 7'h00) else $error("high address bits not masked");
	fill_ones_a: assert property ((state == scratchpad_eeprom_pkg::RD_SP) && (byte_idx == scratchpad_eeprom_pkg::HDR_DATA) && ptr[5] |-> tx_byte == scratchpad_eeprom_pkg::FILL_BYTE) else $error("read past end not ones");
	copy_acc_a: assert property (auth_ok && !bus_reset_i |=> es.copy_accepted_flag && (state == scratchpad_eeprom_pkg::CP_DONE)) else $error("copy not accepted");
	write_full_c: cover property (store && (ptr[4:0] == scratchpad_eeprom_pkg::SP_LAST));
	copy_done_c: cover property (auth_ok);
	overdrive_c: cover property ($rose(od));
	partial_c: cover property (partial_end);
endmodule : scratchpad_eeprom_access

// *** logic/scratchpad_eeprom_pkg.sv ***
// How it works
// - ROM command must precede memory commands
// - Overdrive ROM commands switch to overdrive
// - Exactly four memory commands are decoded
// - All bytes travel least significant bit first
// - Identity is family, serial, then CRC
// - Identity CRC uses x8+x5+x4+1 feedback
// - CRC starts zero, ends zero after CRC
// - Sixteen 32-byte pages plus one scratchpad
// - Two target registers hold the address
// - Status register is read-only to master
// - Low five bits hold last written offset
// - Partial flag marks odd bits or power loss
// - Valid scratchpad write clears partial flag
// - Status bit six always reads zero
// - Storage begins at offset, stops at 1FH
// - Accepted flag meaningful only without partial
// - Write scratchpad command clears accepted flag
// - Full write returns inverted CRC16 to master
// - Read sends addresses, status, then data
// - Copy needs three matching bytes, then copies
// - Incomplete last byte dropped, partial flag set
// - Matching authorisation sets accepted and copies
// - Upper seven address bits forced to zero
// - Reads past scratchpad end return ones
package scratchpad_eeprom_pkg;
	// ROM level commands
	localparam logic [7:0] ROM_READ_CMD = 8'h33;
	localparam logic [7:0] ROM_MATCH_CMD = 8'h55;
	localparam logic [7:0] ROM_SEARCH_CMD = 8'hF0;
	localparam logic [7:0] ROM_SKIP_CMD = 8'hCC;
	localparam logic [7:0] ROM_OD_SKIP_CMD = 8'h3C;
	localparam logic [7:0] ROM_OD_MATCH_CMD = 8'h69;
	// Memory commands
	localparam logic [7:0] MEM_WRITE_SP = 8'h0F;
	localparam logic [7:0] MEM_READ_SP = 8'hAA;
	localparam logic [7:0] MEM_COPY_SP = 8'h55;
	localparam logic [7:0] MEM_READ_MEM = 8'hF0;
	// Layout and fill values
	localparam logic [7:0] ADDR_HIGH_MASK = 8'h01;
	localparam logic [4:0] SP_LAST = 5'h1F;
	localparam logic [7:0] FILL_BYTE = 8'hFF;
	localparam logic [7:0] ALT_BYTE = 8'h55;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [5:0] ROM_LAST = 6'h3F;
	localparam logic [1:0] HDR_LAST = 2'h2;
	localparam logic [1:0] HDR_DATA = 2'h3;
	localparam logic [1:0] SEARCH_RX = 2'h2;
	localparam logic [7:0] CRC8_POLY = 8'h8C;
	localparam logic [15:0] CRC16_POLY = 16'hA001;
	localparam logic [7:0] ES_RESET = 8'h20;

	// Ending offset / status byte
	typedef struct packed {
		logic copy_accepted_flag;
		logic zero;
		logic partial_flag;
		logic [4:0] ending_offset;
	} es_t;

	typedef enum logic [3:0] {
		ROM_CMD, ROM_READ, ROM_MATCH, ROM_SEARCH, MEM_CMD, ADDR_IN,
		WR_DATA, WR_CRC, RD_SP, CP_AUTH, CP_DONE, RD_MEM, IDLE
	} state_t;

	// One CRC8 step, reflected form of x8+x5+x4+1
	function automatic logic [7:0] crc8_bit(logic [7:0] c, logic b);
		logic fb;
		fb = c[0] ^ b;
		crc8_bit = fb ? ((c >> 1) ^ CRC8_POLY) : (c >> 1);
	endfunction : crc8_bit

	function automatic logic [7:0] crc8_run(logic [7:0] c,
			logic [63:0] d, int n);
		logic [7:0] r;
		r = c;
		for (int i = 0; i < n; i++) begin
			r = crc8_bit(r, d[i]);
		end
		crc8_run = r;
	endfunction : crc8_run

	// One CRC16 step, reflected form of x16+x15+x2+1
	function automatic logic [15:0] crc16_bit(logic [15:0] c, logic b);
		logic fb;
		fb = c[0] ^ b;
		crc16_bit = fb ? ((c >> 1) ^ CRC16_POLY) : (c >> 1);
	endfunction : crc16_bit

	function automatic logic [15:0] crc16_byte(logic [15:0] c,
			logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = crc16_bit(r, d[i]);
		end
		crc16_byte = r;
	endfunction : crc16_byte
endpackage : scratchpad_eeprom_pkg

// *** tb/bus_master_model.sv ***
`timescale 1ns/10ps
module bus_master_model (
	// Clock
	input wire logic clk_i,
	// Bit answered by the device
	input wire logic bit_tx_i,
	// Slot events toward the device
	output logic bus_reset_o,
	output logic reset_std_speed_o,
	output logic bit_rx_valid_o,
	output logic bit_rx_o,
	output logic bit_tx_req_o
);
	// Idle edges after each event; raise it to act as a slow master
	int gap = 2;

	// Quiet line at time zero
	initial begin
		bus_reset_o = 1'b0;
		reset_std_speed_o = 1'b1;
		bit_rx_valid_o = 1'b0;
		bit_rx_o = 1'b0;
		bit_tx_req_o = 1'b0;
	end

	// Reset pulse; std tells whether it went out at standard speed
	task automatic line_reset(input logic std);
		@(posedge clk_i);
		bus_reset_o <= 1'b1;
		reset_std_speed_o <= std;
		@(posedge clk_i);
		bus_reset_o <= 1'b0;
		repeat (gap) @(posedge clk_i);
	endtask : line_reset

	// Write slot; data line flips after the slot so no stale value lingers
	task automatic put_bit(input logic b);
		@(posedge clk_i);
		bit_rx_valid_o <= 1'b1;
		bit_rx_o <= b;
		@(posedge clk_i);
		bit_rx_valid_o <= 1'b0;
		bit_rx_o <= ~b;
		repeat (gap) @(posedge clk_i);
	endtask : put_bit

	// Read slot; the answer is taken at the edge that sees the request
	task automatic get_bit(output logic b);
		@(posedge clk_i);
		bit_tx_req_o <= 1'b1;
		@(posedge clk_i);
		b = bit_tx_i;
		bit_tx_req_o <= 1'b0;
		repeat (gap) @(posedge clk_i);
	endtask : get_bit

	task automatic put_byte(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			put_bit(d[i]);
		end
	endtask : put_byte

	task automatic get_byte(output logic [7:0] d);
		logic b;
		for (int i = 0; i < 8; i++) begin
			get_bit(b);
			d[i] = b;
		end
	endtask : get_byte
endmodule : bus_master_model

// *** tb/scratchpad_eeprom_access_tb.sv ***
`timescale 1ns/10ps
module scratchpad_eeprom_access_tb;
	// Identity values are arbitrary
	localparam logic [7:0] FAM = 8'h5A;
	localparam logic [47:0] SER = 48'h0000_1234_ABCD;

	logic clk_i;
	logic rst_b_i;
	logic power_lost_i;
	logic bus_reset, std_speed, rx_valid, rx_bit, tx_req, tx_bit, od;
	logic [7:0] ta_low, ta_high, es;
	logic [63:0] id;
	int bad_count = 0;
	int n_tests = 0;

	// 10 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	scratchpad_eeprom_access #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER))
			scratchpad_eeprom_access_inst (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_reset_i(bus_reset),
		.reset_std_speed_i(std_speed), .bit_rx_valid_i(rx_valid),
		.bit_rx_i(rx_bit), .bit_tx_req_i(tx_req),
		.power_lost_i(power_lost_i), .bit_tx_o(tx_bit),
		.overdrive_speed_select_o(od), .target_address_low_o(ta_low),
		.target_address_high_o(ta_high), .ending_offset_status_o(es));

	bus_master_model bus_master_model_inst (
		.clk_i(clk_i), .bit_tx_i(tx_bit), .bus_reset_o(bus_reset),
		.reset_std_speed_o(std_speed), .bit_rx_valid_o(rx_valid),
		.bit_rx_o(rx_bit), .bit_tx_req_o(tx_req));

	// Reflected shift-register CRC, one byte at a time
	function automatic logic [15:0] crc_step(logic [15:0] c,
			logic [7:0] d, logic [15:0] p);
		for (int i = 0; i < 8; i++) begin
			c = (c[0] ^ d[i]) ? ((c >> 1) ^ p) : (c >> 1);
		end
		return c;
	endfunction : crc_step

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	task automatic check(input string nm, input logic [7:0] seen,
			input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic tx(input logic [7:0] d);
		bus_master_model_inst.put_byte(d);
	endtask : tx

	task automatic rx_chk(input string nm, input logic [7:0] exp);
		logic [7:0] d;
		bus_master_model_inst.get_byte(d);
		check(nm, d, exp);
	endtask : rx_chk

	task automatic sel(input logic std, input logic [7:0] rc);
		bus_master_model_inst.line_reset(std);
		tx(rc);
		if (rc == 8'h55 || rc == 8'h69) begin
			for (int i = 0; i < 8; i++) begin
				tx(id[8*i+:8]);
			end
		end
	endtask : sel

	// Hang guard, far beyond the few thousand cycles the run needs
	initial begin
		repeat (60000) @(posedge clk_i);
		bad_count++;
		stop_test();
	end

	initial begin
		logic [15:0] c;
		logic [7:0] w[7];
		logic b0, b1;
		rst_b_i = 1'b0;
		power_lost_i = 1'b0;
		c = 16'h0000;
		for (int i = 0; i < 7; i++) begin
			c = crc_step(c, 8'({SER, FAM} >> (8 * i)), 16'h008C);
		end
		id = {c[7:0], SER, FAM};
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		check("ta_low", ta_low, 8'h00);
		check("ta_high", ta_high, 8'h00);
		check("es", es, 8'h20);
		// Memory command without selection is ignored
		sel(1'b1, 8'hAA);
		rx_chk("unselected", 8'hFF);
		// Identity readout
		sel(1'b1, 8'h33);
		for (int i = 0; i < 7; i++) begin
			rx_chk("rom", id[8*i+:8]);
		end
		rx_chk("rom_crc", id[63:56]);
		// Search: bit, complement, then our choice
		sel(1'b1, 8'hF0);
		for (int i = 0; i < 64; i++) begin
			bus_master_model_inst.get_bit(b0);
			bus_master_model_inst.get_bit(b1);
			bus_master_model_inst.put_bit(id[i]);
			check("search", {6'h00, b0, b1}, {6'h00, id[i], ~id[i]});
		end
		tx(8'hAA);
		rx_chk("search_sel", 8'h00);
		// Overdrive entry and exit
		sel(1'b1, 8'h3C);
		check("od", {7'h00, od}, 8'h01);
		bus_master_model_inst.line_reset(1'b0);
		check("od_kept", {7'h00, od}, 8'h01);
		bus_master_model_inst.gap = 6;
		sel(1'b1, 8'h69);
		check("od_match", {7'h00, od}, 8'h01);
		tx(8'hAA);
		rx_chk("hdr_lo", 8'h00);
		rx_chk("hdr_hi", 8'h00);
		rx_chk("hdr_es", 8'h20);
		bus_master_model_inst.gap = 2;
		// Two bytes mid page
		sel(1'b1, 8'hCC);
		check("od_off", {7'h00, od}, 8'h00);
		tx(8'h0F);
		tx(8'h26);
		tx(8'h00);
		tx(8'h3A);
		tx(8'hC5);
		bus_master_model_inst.line_reset(1'b1);
		check("ta_low", ta_low, 8'h26);
		check("es", es, 8'h07);
		sel(1'b1, 8'hCC);
		tx(8'hAA);
		w = '{8'h26, 8'h00, 8'h07, 8'h3A, 8'hC5, 8'h00, 8'h00};
		for (int i = 0; i < 5; i++) begin
			rx_chk("rd_sp", w[i]);
		end
		// Power loss marks scratchpad invalid
		@(posedge clk_i);
		power_lost_i <= 1'b1;
		@(posedge clk_i);
		power_lost_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check("es_power", es, 8'h27);
		// Incomplete last byte
		sel(1'b1, 8'hCC);
		tx(8'h0F);
		tx(8'h10);
		tx(8'h00);
		tx(8'h77);
		for (int i = 0; i < 3; i++) begin
			bus_master_model_inst.put_bit(1'b1);
		end
		bus_master_model_inst.line_reset(1'b1);
		check("es_partial", es, 8'h30);
		// partial set, so a fresh write follows
		// mid-page start on purpose, still ends at 1FH
		// Fill to end of scratchpad, high address reduced
		sel(1'b1, 8'hCC);
		w = '{8'h0F, 8'h3C, 8'hFF, 8'h11, 8'h22, 8'h33, 8'h44};
		c = 16'h0000;
		for (int i = 0; i < 7; i++) begin
			tx(w[i]);
			c = crc_step(c, w[i], 16'hA001);
		end
		rx_chk("crc_lo", ~c[7:0]);
		rx_chk("crc_hi", ~c[15:8]);
		rx_chk("after_crc", 8'hFF);
		check("ta_high", ta_high, 8'h01);
		check("es_full", es, 8'h1F);
		sel(1'b1, 8'hCC);
		tx(8'hAA);
		w = '{8'h3C, 8'h01, 8'h1F, 8'h11, 8'h22, 8'h33, 8'h44};
		for (int i = 0; i < 7; i++) begin
			rx_chk("rd_full", w[i]);
		end
		rx_chk("past_end", 8'hFF);
		// Authorisation with the address as first sent is refused
		sel(1'b1, 8'hCC);
		tx(8'h55);
		tx(8'h3C);
		tx(8'hFF);
		tx(8'h1F);
		rx_chk("bad_auth", 8'hFF);
		check("es_noaa", es, 8'h1F);
		sel(1'b1, 8'hCC);
		tx(8'h55);
		tx(8'h3C);
		tx(8'h01);
		tx(8'h1F);
		check("es_aa", es, 8'h9F);
		rx_chk("copy_done", 8'h55);
		sel(1'b1, 8'hCC);
		tx(8'hF0);
		tx(8'h3C);
		tx(8'h01);
		for (int i = 3; i < 7; i++) begin
			rx_chk("mem", w[i]);
		end
		check("es_rdmem", es, 8'h9F);
		// Last memory byte is unwritten, then ones past the end
		sel(1'b1, 8'hCC);
		tx(8'hF0);
		tx(8'hFF);
		tx(8'hFF);
		bus_master_model_inst.get_byte(c[7:0]);
		rx_chk("mem_end", 8'hFF);
		check("ta_high_rd", ta_high, 8'h01);
		// New write command drops the accepted flag
		sel(1'b1, 8'hCC);
		tx(8'h0F);
		bus_master_model_inst.line_reset(1'b1);
		check("aa_clr", {7'h00, es[7]}, 8'h00);
		// Plain match, then an undefined memory command
		sel(1'b1, 8'h55);
		tx(8'h99);
		rx_chk("bad_cmd", 8'hFF);
		stop_test();
	end
endmodule : scratchpad_eeprom_access_tb
